// ===== design/stl_supervisor.sv
// Travel limit and stop-mode supervisor of the servo drive
//
// Summary of operation
// - Direction digit 1 makes clockwise forward
// - Reverse mode negates shaft motion sign only
// - Forward limit high blocks forward motion only
// - Reverse limit high blocks reverse motion only
// - Forward select 1 honours input, 8 ignores
// - Reverse select 2 honours input, 8 ignores
// - Overtravel stop digit picks stop style
// - Emergency torque 0..800 percent, immediate
// - Off command, alarm or power loss disable
// - Servo-off digit picks brake or coast
// - Soft limit overrun stops like overtravel
// - Soft limits armed after homing or a set with valid reference
// - Soft switch digit selects active limits
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module stl_supervisor
  import stl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Limit switch pins and power monitor
  input wire logic i_forward_travel_limit_in,
  input wire logic i_reverse_travel_limit_in,
  input wire logic i_power_loss,
  // Motion controller
  input wire logic i_servo_alarm,
  input wire logic i_homing_done,
  input wire logic i_pos_set,
  input wire logic i_reference_valid_flag,
  input wire logic signed [VEL_W-1:0] i_ref_vel,
  input wire logic signed [POS_W-1:0] i_position,
  input wire logic signed [POS_W-1:0] i_fwd_soft_limit,
  input wire logic signed [POS_W-1:0] i_rev_soft_limit,
  // Drive actions
  output logic o_servo_on,
  output stl_stop_e o_stop_mode,
  output logic signed [VEL_W-1:0] o_motor_vel,
  output logic [TORQUE_W-1:0] o_torque_limit_pct,
  output logic o_fwd_allowed,
  output logic o_rev_allowed,
  output logic o_irq
);

  stl_state_s q;
  stl_state_s d;
  logic [2:0] pins;

  stl_sync #(
    .W(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_power_loss, i_reverse_travel_limit_in,
              i_forward_travel_limit_in}),
    .o_sync(pins)
  );

  function automatic logic [DIGIT_W-1:0] get_digit(
    input logic [DATA_W-1:0] w,
    input int unsigned lsb
  );
    get_digit = w[lsb +: DIGIT_W];
  endfunction

  function automatic stl_stop_e svoff_map(input logic [DIGIT_W-1:0] dg);
    unique case (dg)
      SVOFF_DB_COAST: svoff_map = STOP_DB_COAST;
      SVOFF_COAST: svoff_map = STOP_COAST;
      default: svoff_map = STOP_DB_HOLD;
    endcase
  endfunction

  always_comb
  begin
    logic fwd_pin;
    logic rev_pin;
    logic pwr_lost;
    logic vel_fwd;
    logic vel_rev;
    logic soft_fwd_en;
    logic soft_rev_en;
    logic soft_fwd_hit;
    logic soft_rev_hit;
    logic hw_ot;
    logic soft_ot;
    logic on_cmd;
    logic off_cmd;
    logic [IRQ_W-1:0] ev;
    fwd_pin = pins[0];
    rev_pin = pins[1];
    pwr_lost = pins[2];
    vel_fwd = 1'b0;
    vel_rev = 1'b0;
    soft_fwd_en = 1'b0;
    soft_rev_en = 1'b0;
    soft_fwd_hit = 1'b0;
    soft_rev_hit = 1'b0;
    hw_ot = 1'b0;
    soft_ot = 1'b0;
    on_cmd = 1'b0;
    off_cmd = 1'b0;
    ev = '0;
    d = q;
    vel_fwd = i_ref_vel > 0;
    vel_rev = i_ref_vel < 0;
    // A high pin means open switch, which prohibits that direction
    d.fwd_ok = !(fwd_pin && q.cfg.fwd_sel != SEL_IGNORE);
    d.rev_ok = !(rev_pin && q.cfg.rev_sel != SEL_IGNORE);
    soft_fwd_en = q.soft_armed && (q.cfg.soft_sw == SOFT_BOTH_ON ||
      q.cfg.soft_sw == SOFT_REV_OFF);
    soft_rev_en = q.soft_armed && (q.cfg.soft_sw == SOFT_BOTH_ON ||
      q.cfg.soft_sw == SOFT_FWD_OFF);
    soft_fwd_hit = soft_fwd_en && (i_position > i_fwd_soft_limit);
    soft_rev_hit = soft_rev_en && (i_position < i_rev_soft_limit);
    // Motion away from a limit stays allowed so the axis can back out
    hw_ot = (!d.fwd_ok && vel_fwd) || (!d.rev_ok && vel_rev);
    soft_ot = (soft_fwd_hit && vel_fwd) || (soft_rev_hit && vel_rev);
    d.soft_hit = soft_fwd_hit || soft_rev_hit;
    on_cmd = i_wr && i_addr == ADDR_CMD && i_wdata[CMD_ON_BIT];
    off_cmd = i_wr && i_addr == ADDR_CMD && i_wdata[CMD_OFF_BIT];
    // Turning off beats turning on in the same cycle
    unique case (q.servo)
      SV_ON:
        if (off_cmd || i_servo_alarm || pwr_lost)
          d.servo = SERVO_DISABLE_CMD;
      SERVO_DISABLE_CMD:
        if (on_cmd && !off_cmd && !i_servo_alarm && !pwr_lost)
          d.servo = SV_ON;
    endcase
    unique case (q.servo)
      SERVO_DISABLE_CMD:
        d.stop = svoff_map(q.cfg.svoff_stop);
      SV_ON:
        if (hw_ot || soft_ot)
        begin
          unique case (q.cfg.ot_stop)
            OT_DECEL_ZCLAMP: d.stop = STOP_DECEL_ZCLAMP;
            OT_DECEL_COAST: d.stop = STOP_DECEL_COAST;
            default: d.stop = svoff_map(q.cfg.svoff_stop);
          endcase
        end
        else
          d.stop = STOP_NONE;
    endcase
    if (d.stop != STOP_NONE)
      d.vel = '0;
    else if (q.cfg.dir == DIR_REVERSE)
      d.vel = -i_ref_vel;
    else
      d.vel = i_ref_vel;
    // Position set without a valid reference drops the arming
    if (i_homing_done || (i_pos_set && i_reference_valid_flag))
      d.soft_armed = 1'b1;
    else if (i_pos_set)
      d.soft_armed = 1'b0;
    if (i_wr)
    begin
      unique case (i_addr)
        ADDR_BASIC: d.cfg.dir = get_digit(i_wdata, DIR_LSB);
        ADDR_STOP:
        begin
          d.cfg.svoff_stop = get_digit(i_wdata, SVOFF_STOP_LSB);
          d.cfg.ot_stop = get_digit(i_wdata, OT_STOP_LSB);
        end
        ADDR_FWD_SEL: d.cfg.fwd_sel = get_digit(i_wdata, FWD_SEL_LSB);
        ADDR_REV_SEL: d.cfg.rev_sel = get_digit(i_wdata, REV_SEL_LSB);
        // Values above full scale saturate rather than wrap
        ADDR_ESTOP_TRQ: d.cfg.torque = (i_wdata > TORQUE_MAX_W) ?
          TORQUE_MAX : i_wdata[TORQUE_W-1:0];
        ADDR_SOFT_SW: d.cfg.soft_sw = get_digit(i_wdata, SOFT_SW_LSB);
        ADDR_IRQ_MASK: d.mask = i_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    ev[IRQ_FWD_OT] = q.fwd_ok && !d.fwd_ok;
    ev[IRQ_REV_OT] = q.rev_ok && !d.rev_ok;
    ev[IRQ_SOFT] = !q.soft_hit && d.soft_hit;
    ev[IRQ_SVOFF] = q.servo == SV_ON && d.servo == SERVO_DISABLE_CMD;
    // Read clears, but a new event in the same cycle survives
    if (i_rd && i_addr == ADDR_IRQ_STAT)
      d.irq = ev;
    else
      d.irq = q.irq | ev;
    d.irq_out = |(d.irq & d.mask);
    d.rdata = '0;
    if (i_rd)
    begin
      unique case (i_addr)
        ADDR_BASIC: d.rdata[DIR_LSB +: DIGIT_W] = q.cfg.dir;
        ADDR_STOP:
        begin
          d.rdata[SVOFF_STOP_LSB +: DIGIT_W] = q.cfg.svoff_stop;
          d.rdata[OT_STOP_LSB +: DIGIT_W] = q.cfg.ot_stop;
        end
        ADDR_FWD_SEL: d.rdata[FWD_SEL_LSB +: DIGIT_W] = q.cfg.fwd_sel;
        ADDR_REV_SEL: d.rdata[REV_SEL_LSB +: DIGIT_W] = q.cfg.rev_sel;
        ADDR_ESTOP_TRQ: d.rdata[TORQUE_W-1:0] = q.cfg.torque;
        ADDR_SOFT_SW: d.rdata[SOFT_SW_LSB +: DIGIT_W] = q.cfg.soft_sw;
        ADDR_STATUS:
        begin
          d.rdata[ST_SERVO_BIT] = q.servo == SV_ON;
          d.rdata[ST_FWD_OK_BIT] = q.fwd_ok;
          d.rdata[ST_REV_OK_BIT] = q.rev_ok;
          d.rdata[ST_ARMED_BIT] = q.soft_armed;
          d.rdata[ST_STOP_LSB +: 3] = q.stop;
        end
        ADDR_IRQ_STAT: d.rdata[IRQ_W-1:0] = q.irq;
        ADDR_IRQ_MASK: d.rdata[IRQ_W-1:0] = q.mask;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      q <= '0;
      q.cfg <= CFG_RESET;
      q.servo <= SERVO_DISABLE_CMD;
      q.fwd_ok <= 1'b1;
      q.rev_ok <= 1'b1;
      q.stop <= STOP_DB_HOLD;
    end
    else
      q <= d;
  end

  assign o_rdata = q.rdata;
  assign o_servo_on = q.servo;
  assign o_stop_mode = q.stop;
  assign o_motor_vel = q.vel;
  assign o_torque_limit_pct = q.cfg.torque;
  assign o_fwd_allowed = q.fwd_ok;
  assign o_rev_allowed = q.rev_ok;
  assign o_irq = q.irq_out;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_trq_write;
    i_wr && i_addr == ADDR_ESTOP_TRQ && i_wdata <= TORQUE_MAX_W;
  endsequence

  sequence s_drop_cause;
    i_servo_alarm || (i_wr && i_addr == ADDR_CMD && i_wdata[CMD_OFF_BIT]);
  endsequence

  sequence s_fwd_push;
    o_servo_on && pins[0] && q.cfg.fwd_sel != SEL_IGNORE && i_ref_vel > 0;
  endsequence

  sequence s_rev_push;
    o_servo_on && pins[1] && q.cfg.rev_sel != SEL_IGNORE && i_ref_vel < 0;
  endsequence

  a_dir_sense: assert property (
    o_stop_mode == STOP_NONE |-> o_motor_vel == ($past(q.cfg.dir) ==
      DIR_REVERSE ? -$past(i_ref_vel) : $past(i_ref_vel)))
    else $error("motor velocity sign wrong");
  a_fwd_block: assert property (
    s_fwd_push |=> !o_fwd_allowed && o_stop_mode != STOP_NONE)
    else $error("forward motion not blocked");
  a_rev_block: assert property (
    s_rev_push |=> !o_rev_allowed && o_stop_mode != STOP_NONE)
    else $error("reverse motion not blocked");
  a_fwd_ignore: assert property (
    q.cfg.fwd_sel == SEL_IGNORE |=> o_fwd_allowed)
    else $error("ignored forward limit blocked motion");
  a_rev_ignore: assert property (
    q.cfg.rev_sel == SEL_IGNORE |=> o_rev_allowed)
    else $error("ignored reverse limit blocked motion");
  a_rev_allow: assert property (
    !pins[1] |=> o_rev_allowed)
    else $error("reverse blocked with limit low");
  a_ot_zclamp: assert property (
    s_fwd_push and q.cfg.ot_stop == OT_DECEL_ZCLAMP
      |=> o_stop_mode == STOP_DECEL_ZCLAMP)
    else $error("overtravel stop style wrong");
  a_trq_write: assert property (
    s_trq_write |=> o_torque_limit_pct == $past(i_wdata[TORQUE_W-1:0]))
    else $error("emergency torque not applied");
  a_servo_drop: assert property (
    s_drop_cause |=> !o_servo_on ##1 o_stop_mode != STOP_NONE)
    else $error("servo did not switch off");
  a_svoff_coast: assert property (
    !o_servo_on && q.cfg.svoff_stop == SVOFF_COAST
      |=> o_stop_mode == STOP_COAST)
    else $error("servo-off stop style wrong");
  a_soft_arm: assert property (
    i_homing_done |=> q.soft_armed)
    else $error("soft limits not armed after homing");

endmodule // stl_supervisor

// ===== design/stl_pkg.sv
// Constants, types and register map of the servo travel limit supervisor
package stl_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned VEL_W = 24;
  localparam int unsigned POS_W = 32;
  localparam int unsigned TORQUE_W = 10;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned DIGIT_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_BASIC = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STOP = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_FWD_SEL = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_REV_SEL = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_ESTOP_TRQ = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_SW = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h09;

  // Digit positions inside the setting words
  localparam int unsigned DIR_LSB = 0;
  localparam int unsigned SVOFF_STOP_LSB = 0;
  localparam int unsigned OT_STOP_LSB = 4;
  localparam int unsigned FWD_SEL_LSB = 12;
  localparam int unsigned REV_SEL_LSB = 0;
  localparam int unsigned SOFT_SW_LSB = 0;

  // Digit values
  localparam logic [DIGIT_W-1:0] DIR_REVERSE = 4'h1;
  localparam logic [DIGIT_W-1:0] SVOFF_DB_HOLD = 4'h0;
  localparam logic [DIGIT_W-1:0] SVOFF_DB_COAST = 4'h1;
  localparam logic [DIGIT_W-1:0] SVOFF_COAST = 4'h2;
  localparam logic [DIGIT_W-1:0] OT_AS_SVOFF = 4'h0;
  localparam logic [DIGIT_W-1:0] OT_DECEL_ZCLAMP = 4'h1;
  localparam logic [DIGIT_W-1:0] OT_DECEL_COAST = 4'h2;
  localparam logic [DIGIT_W-1:0] FWD_SEL_USE = 4'h1;
  localparam logic [DIGIT_W-1:0] REV_SEL_USE = 4'h2;
  localparam logic [DIGIT_W-1:0] SEL_IGNORE = 4'h8;
  localparam logic [DIGIT_W-1:0] SOFT_BOTH_ON = 4'h0;
  localparam logic [DIGIT_W-1:0] SOFT_FWD_OFF = 4'h1;
  localparam logic [DIGIT_W-1:0] SOFT_REV_OFF = 4'h2;
  localparam logic [DIGIT_W-1:0] SOFT_BOTH_OFF = 4'h3;

  localparam logic [TORQUE_W-1:0] TORQUE_MAX = 10'h320;
  localparam logic [DATA_W-1:0] TORQUE_MAX_W = 16'h0320;

  // Command and status bits
  localparam int unsigned CMD_ON_BIT = 0;
  localparam int unsigned CMD_OFF_BIT = 1;
  localparam int unsigned ST_SERVO_BIT = 0;
  localparam int unsigned ST_FWD_OK_BIT = 1;
  localparam int unsigned ST_REV_OK_BIT = 2;
  localparam int unsigned ST_ARMED_BIT = 3;
  localparam int unsigned ST_STOP_LSB = 4;
  localparam int unsigned IRQ_FWD_OT = 0;
  localparam int unsigned IRQ_REV_OT = 1;
  localparam int unsigned IRQ_SOFT = 2;
  localparam int unsigned IRQ_SVOFF = 3;

  typedef enum logic [2:0] {
    STOP_NONE = 3'h0,
    STOP_DB_HOLD = 3'h1,
    STOP_DB_COAST = 3'h2,
    STOP_COAST = 3'h3,
    STOP_DECEL_ZCLAMP = 3'h4,
    STOP_DECEL_COAST = 3'h5
  } stl_stop_e;

  typedef enum logic [0:0] {
    SERVO_DISABLE_CMD = 1'h0,
    SV_ON = 1'h1
  } stl_servo_e;

  typedef struct packed {
    logic [DIGIT_W-1:0] dir;
    logic [DIGIT_W-1:0] svoff_stop;
    logic [DIGIT_W-1:0] ot_stop;
    logic [DIGIT_W-1:0] fwd_sel;
    logic [DIGIT_W-1:0] rev_sel;
    logic [DIGIT_W-1:0] soft_sw;
    logic [TORQUE_W-1:0] torque;
  } stl_cfg_s;

  localparam stl_cfg_s CFG_RESET = '{dir: 4'h0, svoff_stop: SVOFF_DB_HOLD,
    ot_stop: OT_AS_SVOFF, fwd_sel: FWD_SEL_USE, rev_sel: REV_SEL_USE,
    soft_sw: SOFT_BOTH_OFF, torque: TORQUE_MAX};

  typedef struct packed {
    stl_cfg_s cfg;
    stl_servo_e servo;
    logic soft_armed;
    logic fwd_ok;
    logic rev_ok;
    logic soft_hit;
    logic [IRQ_W-1:0] irq;
    logic [IRQ_W-1:0] mask;
    logic irq_out;
    stl_stop_e stop;
    logic signed [VEL_W-1:0] vel;
    logic [DATA_W-1:0] rdata;
  } stl_state_s;

endpackage

// ===== design/stl_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module stl_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } stl_sync_s;

  stl_sync_s q;
  stl_sync_s d;

  // First stage feeds only the second stage
  always_comb
  begin
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      q <= '0;
    else
      q <= d;
  end

  assign o_sync = q.s2;

endmodule // stl_sync

// ===== tb/stl_far_model.sv
// Motion controller and limit switch model facing the supervisor
`timescale 1ns/1ps
module stl_far_model
  import stl_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Switch pins, power monitor and servo alarm
  output logic o_fwd_pin,
  output logic o_rev_pin,
  output logic o_pwr_loss,
  output logic o_alarm,
  // Controller commands and motion
  output logic o_home,
  output logic o_set,
  output logic o_ref_ok,
  output logic signed [VEL_W-1:0] o_vel,
  output logic signed [POS_W-1:0] o_pos,
  output logic signed [POS_W-1:0] o_fwd_lim,
  output logic signed [POS_W-1:0] o_rev_lim
);
  // Limits kept reverse below forward, as the drive expects
  initial
  begin
    {o_fwd_pin, o_rev_pin, o_pwr_loss, o_alarm} = 4'h0;
    {o_home, o_set, o_ref_ok} = 3'h0;
    o_vel = 24'sh0;
    o_pos = 32'sh0;
    o_fwd_lim = 32'sh1000;
    o_rev_lim = -32'sh1000;
  end

  task automatic set_pins(input logic f, input logic r, input logic p,
    input logic a);
    @(posedge i_clk);
    {o_fwd_pin, o_rev_pin, o_pwr_loss, o_alarm} <= {f, r, p, a};
  endtask

  task automatic move(input logic signed [VEL_W-1:0] v,
    input logic signed [POS_W-1:0] p);
    @(posedge i_clk);
    o_vel <= v;
    o_pos <= p;
  endtask

  // One-cycle homing or position-set pulse with its flag
  task automatic cmd(input logic hm, input logic flag);
    @(posedge i_clk);
    o_home <= hm;
    o_set <= !hm;
    o_ref_ok <= flag;
    @(posedge i_clk);
    {o_home, o_set} <= 2'h0;
  endtask
endmodule // stl_far_model

// ===== tb/stl_supervisor_tb.sv
// Self-checking bench for the travel limit supervisor
`timescale 1ns/1ps
module stl_supervisor_tb
  import stl_pkg::*;
;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic bus_wr;
  logic bus_rd;
  logic [DATA_W-1:0] rdata;
  logic fwd_pin, rev_pin, pwr_loss, alarm, home, pset, ref_ok;
  logic signed [VEL_W-1:0] ref_vel;
  logic signed [VEL_W-1:0] motor_vel;
  logic signed [POS_W-1:0] pos, fwd_lim, rev_lim;
  logic servo_on, fwd_ok, rev_ok, irq;
  stl_stop_e stop_mode;
  logic [TORQUE_W-1:0] trq;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  stl_supervisor DUT (
    .i_clk(clk), .i_reset(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd),
    .o_rdata(rdata),
    .i_forward_travel_limit_in(fwd_pin),
    .i_reverse_travel_limit_in(rev_pin),
    .i_power_loss(pwr_loss), .i_servo_alarm(alarm),
    .i_homing_done(home), .i_pos_set(pset),
    .i_reference_valid_flag(ref_ok), .i_ref_vel(ref_vel),
    .i_position(pos), .i_fwd_soft_limit(fwd_lim),
    .i_rev_soft_limit(rev_lim),
    .o_servo_on(servo_on), .o_stop_mode(stop_mode),
    .o_motor_vel(motor_vel), .o_torque_limit_pct(trq),
    .o_fwd_allowed(fwd_ok), .o_rev_allowed(rev_ok), .o_irq(irq)
  );

  stl_far_model far (
    .i_clk(clk), .o_fwd_pin(fwd_pin), .o_rev_pin(rev_pin),
    .o_pwr_loss(pwr_loss), .o_alarm(alarm), .o_home(home),
    .o_set(pset), .o_ref_ok(ref_ok), .o_vel(ref_vel), .o_pos(pos),
    .o_fwd_lim(fwd_lim), .o_rev_lim(rev_lim)
  );

  initial
  begin
    clk = 1'b0;
  end
  always #25 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Generous ceiling; the whole sequence needs well under a thousand
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] exp);
    @(posedge clk);
    addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic t_reset();
    chk({servo_on, fwd_ok, rev_ok, irq}, 4'h6);
    chk(stop_mode, STOP_DB_HOLD);
    chk(trq, 10'h320);
    reg_rd(ADDR_FWD_SEL, 16'h1000);
    reg_rd(ADDR_REV_SEL, 16'h0002);
    reg_rd(ADDR_SOFT_SW, 16'h0003);
    reg_rd(ADDR_STATUS, 16'h0016);
    reg_rd(8'h0a, 16'h0000);
  endtask

  task automatic t_off();
    stl_stop_e off_m [3] = '{STOP_DB_HOLD, STOP_DB_COAST, STOP_COAST};
    // On and off in one write: off wins
    reg_wr(ADDR_CMD, 16'h0003);
    settle(1);
    chk(servo_on, 1'b0);
    reg_wr(ADDR_CMD, 16'h0001);
    reg_wr(ADDR_CMD, 16'h0002);
    settle(2);
    chk(irq, 1'b0);
    reg_rd(ADDR_IRQ_STAT, 16'h0008);
    reg_wr(ADDR_IRQ_MASK, 16'h0008);
    for (int c = 0; c < 3; c++)
    begin
      reg_wr(ADDR_STOP, 16'(c));
      reg_wr(ADDR_CMD, 16'h0001);
      settle(1);
      chk(servo_on, 1'b1);
      if (c == 0)
        reg_wr(ADDR_CMD, 16'h0002);
      else
        far.set_pins(0, 0, c == 2, c == 1);
      settle(5);
      chk(servo_on, 1'b0);
      chk(stop_mode, off_m[c]);
      chk(irq, 1'b1);
      reg_rd(ADDR_IRQ_STAT, 16'h0008);
      reg_rd(ADDR_IRQ_STAT, 16'h0000);
      chk(irq, 1'b0);
      // Enable must be refused while alarm or power loss persists
      reg_wr(ADDR_CMD, 16'h0001);
      settle(2);
      chk(servo_on, c == 0);
      reg_wr(ADDR_CMD, 16'h0002);
      far.set_pins(0, 0, 0, 0);
      // Power-loss level must clear the synchroniser before the next enable
      settle(3);
    end
  endtask

  task automatic t_dir();
    reg_wr(ADDR_CMD, 16'h0001);
    far.move(24'sh64, 32'sh0);
    settle(4);
    chk(motor_vel, 24'sh64);
    reg_wr(ADDR_BASIC, 16'(DIR_REVERSE));
    settle(2);
    chk(motor_vel, -24'sh64);
    far.move(-24'sh64, 32'sh0);
    settle(3);
    chk(motor_vel, 24'sh64);
    reg_wr(ADDR_BASIC, 16'h0000);
  endtask

  task automatic t_hw();
    stl_stop_e ot_m [3] = '{STOP_DB_HOLD, STOP_DECEL_ZCLAMP,
      STOP_DECEL_COAST};
    logic signed [VEL_W-1:0] v;
    for (int d = 0; d < 3; d++)
      for (int s = 0; s < 2; s++)
      begin
        v = s ? -24'sh64 : 24'sh64;
        reg_wr(ADDR_STOP, 16'(d) << OT_STOP_LSB);
        far.set_pins(!s, s, 0, 0);
        far.move(v, 32'sh0);
        settle(5);
        chk(fwd_ok, s);
        chk(rev_ok, !s);
        chk(stop_mode, ot_m[d]);
        far.move(-v, 32'sh0);
        settle(3);
        chk(motor_vel, -v);
      end
    far.set_pins(0, 0, 0, 0);
  endtask

  task automatic t_sel_trq();
    logic [DATA_W-1:0] w [4] = '{16'h01f4, 16'h0000, 16'h0384, 16'h0320};
    logic [TORQUE_W-1:0] e [4] = '{10'h1f4, 10'h000, 10'h320, 10'h320};
    reg_wr(ADDR_FWD_SEL, 16'h8000);
    reg_wr(ADDR_REV_SEL, 16'h0008);
    far.set_pins(1, 1, 0, 0);
    settle(5);
    chk({fwd_ok, rev_ok}, 2'h3);
    reg_wr(ADDR_FWD_SEL, 16'h1000);
    reg_wr(ADDR_REV_SEL, 16'h0002);
    settle(2);
    chk({fwd_ok, rev_ok}, 2'h0);
    far.set_pins(0, 0, 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(ADDR_ESTOP_TRQ, w[i]);
      settle(1);
      chk(trq, e[i]);
    end
  endtask

  task automatic t_soft();
    reg_wr(ADDR_STOP, 16'h0010);
    reg_wr(ADDR_SOFT_SW, 16'h0000);
    far.move(24'sh64, 32'sh2000);
    // Unarmed, home, disarm by set without flag, arm by set with flag
    for (int k = 0; k < 4; k++)
    begin
      far.cmd(k == 1, k == 3);
      settle(4);
      chk(stop_mode, k[0] ? STOP_DECEL_ZCLAMP : STOP_NONE);
    end
    for (int d = 0; d < 4; d++)
      for (int s = 0; s < 2; s++)
      begin
        reg_wr(ADDR_SOFT_SW, 16'(d));
        far.move(s ? -24'sh64 : 24'sh64, s ? -32'sh2000 : 32'sh2000);
        settle(4);
        chk(stop_mode, d[s] ? STOP_NONE : STOP_DECEL_ZCLAMP);
      end
    reg_wr(ADDR_SOFT_SW, 16'h0000);
    far.move(24'sh64, 32'sh1000);
    settle(4);
    chk(stop_mode, STOP_NONE);
    far.move(24'sh64, 32'sh1001);
    settle(4);
    chk(stop_mode, STOP_DECEL_ZCLAMP);
  endtask

  initial
  begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle(4);
    t_reset();
    t_off();
    t_dir();
    t_hw();
    t_sel_trq();
    t_soft();
    tally_and_finish();
  end
endmodule // stl_supervisor_tb
